// File: design/quad_dac_regs.vh
// register image layout and timing constants of the four-channel output port
`ifndef QUAD_DAC_REGS_VH
`define QUAD_DAC_REGS_VH
// two byte-wide image locations, sixteen points
`define POINT_COUNT 16
`define IMAGE_LOW 1'b0
`define IMAGE_HIGH 1'b1
// upper image: bits 3:0 data 11:8, bits 7:4 channel selects
`define HIGH_DATA_MSB 3
`define SEL_LSB 4
`define SEL_MSB 7
`define CHAN_COUNT 4
`define CODE_BITS 12
`define CODE_MAX 12'hFFF
`define CODE_RESET 12'h000
// conversion time in ns and cycles at 100 MHz, longest time rounds down
`define CONV_TIME_NS 30000
`define CLK_PERIOD_NS 10
`define CONV_CYCLES (`CONV_TIME_NS / `CLK_PERIOD_NS)
`endif

// File: design/quad_dac_output_update_port.v
// scan-bus output port that loads 12-bit codes into four converter channels
`include "quad_dac_regs.vh"
module quad_dac_output_update_port #(
   parameter CONV_CYCLES = `CONV_CYCLES
) (
   input wire ref_clk,
   input wire rst,
   input wire bus_wr,
   input wire bus_addr,
   input wire [7:0] bus_wdata,
   input wire scan_end,
   input wire conv_done,
   output reg conv_start,
   output reg [1:0] conv_chan,
   output reg [11:0] conv_code,
   output reg conv_busy,
   output reg conv_timeout,
   output reg [47:0] chan_codes
);

//------------------------------------------------------------
// input synchronisers
//------------------------------------------------------------
reg [1:0] wr_s;
reg [1:0] addr_s;
reg [7:0] data_s0;
reg [7:0] data_s1;
reg [1:0] scan_s;
reg [1:0] done_s;
reg wr_d;
reg scan_d;
always @(posedge ref_clk or posedge rst) begin
   if (rst) begin
      wr_s <= 2'h0;
      addr_s <= 2'h0;
      data_s0 <= 8'h00;
      data_s1 <= 8'h00;
      scan_s <= 2'h0;
      done_s <= 2'h0;
      wr_d <= 1'b0;
      scan_d <= 1'b0;
   end else begin
      wr_s <= {wr_s[0], bus_wr};
      addr_s <= {addr_s[0], bus_addr};
      data_s0 <= bus_wdata;
      data_s1 <= data_s0;
      scan_s <= {scan_s[0], scan_end};
      done_s <= {done_s[0], conv_done};
      wr_d <= wr_s[1];
      scan_d <= scan_s[1];
   end
end
wire wr_rise = wr_s[1] & ~wr_d;
wire scan_rise = scan_s[1] & ~scan_d;

//------------------------------------------------------------
// register image
//------------------------------------------------------------
reg [7:0] output_data_low_byte_reg;
reg [7:0] output_data_high_and_channel_select_reg;
always @(posedge ref_clk or posedge rst) begin
   if (rst) begin
      output_data_low_byte_reg <= 8'h00;
      output_data_high_and_channel_select_reg <= 8'h00;
   end else if (wr_rise) begin
      if (addr_s[1] == `IMAGE_LOW)
         output_data_low_byte_reg <= data_s1;
      else
         output_data_high_and_channel_select_reg <= data_s1;
   end
end
wire [11:0] image_code = {
   output_data_high_and_channel_select_reg[`HIGH_DATA_MSB:0],
   output_data_low_byte_reg};
wire [3:0] image_sel =
   output_data_high_and_channel_select_reg[`SEL_MSB:`SEL_LSB];

//------------------------------------------------------------
// sequencer state
//------------------------------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_CONV = 2'h1;
localparam ST_WAIT = 2'h2;
localparam [15:0] CONV_LAST = CONV_CYCLES[15:0] - 16'h0001;
reg [1:0] state_reg;
reg [1:0] state_next;
reg [1:0] rr_reg;
reg [1:0] rr_next;
reg [15:0] timer_reg;
reg [15:0] timer_next;
reg [11:0] code_lat;
reg [11:0] code_next;
reg [1:0] chan_next;
reg start_next;
reg busy_next;
reg timeout_next;
reg load_en;
reg [1:0] pick;
reg [1:0] cand;
reg pick_ok;
integer i;
integer j;

//------------------------------------------------------------
// channel pick
//------------------------------------------------------------
// round-robin, search starts after the channel served last
always @* begin
   pick = 2'h0;
   pick_ok = 1'b0;
   cand = 2'h0;
   for (i = `CHAN_COUNT - 1; i >= 0; i = i - 1) begin
      cand = rr_reg + i[1:0];
      if (image_sel[cand]) begin
         pick = cand;
         pick_ok = 1'b1;
      end
   end
end

//------------------------------------------------------------
// conversion timer
//------------------------------------------------------------
// a missing done still ends the wait after the conversion time
wire conv_end = done_s[1] ||
   (timer_reg == CONV_LAST);

//------------------------------------------------------------
// next-state logic
//------------------------------------------------------------
always @* begin
   state_next = state_reg;
   rr_next = rr_reg;
   timer_next = timer_reg;
   code_next = code_lat;
   chan_next = conv_chan;
   start_next = 1'b0;
   busy_next = conv_busy;
   timeout_next = conv_timeout;
   load_en = 1'b0;
   case (state_reg)
      ST_IDLE: begin
         if (scan_rise && pick_ok) begin
            chan_next = pick;
            code_next = image_code;
            start_next = 1'b1;
            busy_next = 1'b1;
            timeout_next = 1'b0;
            timer_next = 16'h0000;
            rr_next = pick + 2'h1;
            state_next = ST_CONV;
         end
      end
      ST_CONV: begin
         timer_next = timer_reg + 16'h0001;
         if (conv_end) begin
            timeout_next = ~done_s[1];
            load_en = 1'b1;
            busy_next = 1'b0;
            state_next = ST_WAIT;
         end
      end
      ST_WAIT: begin
         // converter must drop done before the next start
         if (~done_s[1])
            state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
   endcase
end

//------------------------------------------------------------
// sequencer registers
//------------------------------------------------------------
always @(posedge ref_clk or posedge rst) begin
   if (rst) begin
      state_reg <= ST_IDLE;
      rr_reg <= 2'h0;
      timer_reg <= 16'h0000;
      code_lat <= `CODE_RESET;
      conv_start <= 1'b0;
      conv_chan <= 2'h0;
      conv_code <= `CODE_RESET;
      conv_busy <= 1'b0;
      conv_timeout <= 1'b0;
   end else begin
      state_reg <= state_next;
      rr_reg <= rr_next;
      timer_reg <= timer_next;
      code_lat <= code_next;
      conv_start <= start_next;
      conv_chan <= chan_next;
      conv_code <= code_next;
      conv_busy <= busy_next;
      conv_timeout <= timeout_next;
   end
end

//------------------------------------------------------------
// channel hold registers
//------------------------------------------------------------
always @(posedge ref_clk or posedge rst) begin
   if (rst) begin
      chan_codes <= {`CHAN_COUNT{`CODE_RESET}};
   end else begin
      for (j = 0; j < `CHAN_COUNT; j = j + 1) begin
         if (load_en && conv_chan == j[1:0])
            chan_codes[j*`CODE_BITS +: `CODE_BITS] <= code_lat;
      end
   end
end
endmodule // quad_dac_output_update_port

// File: verif/quad_dac_asserts.sv
// checker of the converter handshake
module quad_dac_asserts #(parameter CONV_CYCLES = 20) (
   input wire ref_clk, rst, bus_wr, bus_addr, scan_end, conv_done,
   input wire [7:0] bus_wdata,
   input wire conv_start, conv_busy, conv_timeout,
   input wire [1:0] conv_chan,
   input wire [11:0] conv_code,
   input wire [47:0] chan_codes
);
   timeunit 1ns; timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_end; conv_busy && conv_done; endsequence
   property p_pulse; conv_start |=> !conv_start; endproperty
   a_pulse: assert property (p_pulse) else $error("long start");
   property p_busy; conv_start |-> conv_busy; endproperty
   a_busy: assert property (p_busy) else $error("idle start");
   property p_rise; $rose(conv_busy) |-> conv_start; endproperty
   a_rise: assert property (p_rise) else $error("busy no start");
   property p_done; s_end |-> ##[1:4] !conv_busy; endproperty
   a_done: assert property (p_done) else $error("busy stuck");
   property p_one; conv_busy |=> !conv_start; endproperty
   a_one: assert property (p_one) else $error("start in busy");
   property p_hold; !conv_start |-> $stable({conv_chan, conv_code}); endproperty
   a_hold: assert property (p_hold) else $error("code moved");
   property p_keep; !$stable(chan_codes) |-> $fell(conv_busy); endproperty
   a_keep: assert property (p_keep) else $error("codes moved");
   property p_load;
      $fell(conv_busy) |-> chan_codes[conv_chan*12 +: 12] == conv_code;
   endproperty
   a_load: assert property (p_load) else $error("bad load");
endmodule // quad_dac_asserts
bind quad_dac_output_update_port quad_dac_asserts #(
   .CONV_CYCLES(CONV_CYCLES)) u_chk (.*);

// File: verif/conv_model.sv
// converter model answering start pulses
module conv_model (
   input wire logic ref_clk, rst, conv_start, slow,
   output logic conv_done = 1'b0
);
   timeunit 1ns; timeprecision 1ps;
   int n = 0;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         n <= 0;
         conv_done <= 1'b0;
      end else begin
         if (conv_start && !slow) n <= 1;
         else if (n != 0) n <= n + 1;
         if (n == 12) n <= 0;
         conv_done <= n >= 8 && n < 12;
      end
   end
endmodule // conv_model

// File: verif/tb.sv
// self-checking bench of the output port
module tb;
   timeunit 1ns; timeprecision 1ps;
   logic ref_clk = 0, rst = 1, bus_wr = 0, bus_addr = 0, scan_end = 0;
   logic slow = 0;
   logic [7:0] bus_wdata = 8'h00;
   wire conv_done, conv_start, conv_busy, conv_timeout;
   wire [1:0] conv_chan;
   wire [11:0] conv_code;
   wire [47:0] chan_codes;
   int mismatches = 0, compares = 0, cyc = 0, last = 3, i, c;
   logic [15:0] lf = 16'hCB2B;
   logic [47:0] exp_codes = 48'h0;
   logic [11:0] code;
   logic [3:0] sel;
   always #5 ref_clk = ~ref_clk;
   quad_dac_output_update_port #(.CONV_CYCLES(20)) DUT (.ref_clk(ref_clk),
      .rst(rst), .bus_wr(bus_wr), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .scan_end(scan_end), .conv_done(conv_done),
      .conv_start(conv_start), .conv_chan(conv_chan),
      .conv_code(conv_code), .conv_busy(conv_busy),
      .conv_timeout(conv_timeout), .chan_codes(chan_codes));
   conv_model u_cnv (.ref_clk(ref_clk), .rst(rst), .conv_start(conv_start),
      .slow(slow), .conv_done(conv_done));
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [11:0] bcd2bin(input logic [15:0] v);
      return 12'(v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0]);
   endfunction
   task chk(input logic [47:0] s, e, input string n);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task pulse(input logic s, a, input logic [7:0] d);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = !s;
      scan_end = s;
      repeat (4) @(posedge ref_clk) #1;
      bus_wr = 0;
      scan_end = 0;
      repeat (4) @(posedge ref_clk) #1;
   endtask
   task wt(input logic v);
      for (int k = 0; k < 40 && conv_busy !== v; k++) @(posedge ref_clk) #1;
      chk(conv_busy, v, "conv_busy");
   endtask
   task upd;
      pulse(0, 0, code[7:0]);
      pulse(0, 1, {sel, code[11:8]});
      pulse(1, 0, 8'h00);
      if (sel == 0) begin
         chk(conv_busy, 1'b0, "conv_busy");
      end else begin
         wt(1);
         wt(0);
         c = last;
         do c = (c + 1) % 4; while (!sel[c]);
         last = c;
         exp_codes[c*12 +: 12] = code;
         chk(conv_chan, c, "conv_chan");
         chk(conv_code, code, "conv_code");
      end
      chk(chan_codes, exp_codes, "chan_codes");
      chk(conv_timeout, slow, "conv_timeout");
   endtask
   task summarize;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         summarize;
      end
   end
   initial begin
      repeat (3) @(posedge ref_clk) #1;
      rst = 0;
      for (i = 0; i < 10; i++) begin
         lf = lfsr(lf);
         code = i == 0 ? 12'hFFF : i == 1 ? 12'h000 : lf[11:0];
         sel = i == 4 ? 4'h0 : lf[15:12] == 0 ? 4'h1 : lf[15:12];
         slow = i == 9;
         upd;
      end
      rst = 1;
      repeat (2) @(posedge ref_clk) #1;
      chk(chan_codes, 48'h0, "reset chan_codes");
      chk(conv_timeout, 1'b0, "reset conv_timeout");
      chk(conv_busy, 1'b0, "reset conv_busy");
      rst = 0;
      slow = 0;
      exp_codes = 48'h0;
      last = 3;
      code = 12'hC35;
      sel = 4'h1;
      upd;
      code = 12'h000;
      sel = 4'h2;
      upd;
      code = 12'h000;
      sel = 4'h1;
      upd;
      code = lf[11:0];
      sel = 4'h2;
      upd;
      code = bcd2bin(16'h1720);
      sel = 4'h8;
      upd;
      chk(chan_codes[47:36], 12'h6B8, "bcd chan_codes");
      summarize;
   end
endmodule // tb
